// >>> dv/sps_pad_env.sv
/* Board-side model of the general pads.
   Assumes one core clock; a released pad is not held by the board. */
`timescale 1ns/1ps
module sps_pad_env
#(
	parameter int N = 8 // Pad count
)
(
	input  wire logic         clk,     // Core clock
	input  wire logic [N-1:0] pad_out, // Device pad data
	input  wire logic [N-1:0] pad_oe,  // Device drive enable
	output logic      [N-1:0] pad_in   // Pad level seen
);
	logic [N-1:0] wander_q = '0;
	// Released pads flip each cycle so a stale level never passes
	always @(posedge clk)
		wander_q <= ~wander_q;
	// Device drive wins, else the wandering level
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & wander_q);
endmodule : sps_pad_env

// >>> dv/sps_pin_state_ctrl_asserts.sv
/* Port checker for the standby pin-state controller.
   Assumes a bind onto sps_pin_state_ctrl, one clock, pin 1 peri, 2 analog, 4 wake. */
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_pin_state_ctrl_asserts
	import sps_pkg::*;
#(
	parameter int N_PINS = 8 // General pins
)
(
	input wire logic                          CORE_CLK,              // Clock
	input wire logic                          RESET,                 // Reset
	input wire logic                          INT_RESET,             // Internal reset
	input wire logic                          EXT_RESET_CORE,        // Synchronised reset pin
	input wire logic [`SPS_MODE_W-1:0]        POWER_MODE,            // Mode
	input wire logic                          STANDBY_PIN_LEVEL_SEL, // Level bit
	input wire logic [N_PINS*`SPS_FUNC_W-1:0] PIN_FUNC,              // Functions
	input wire logic [N_PINS-1:0]             PAD_OE,                // Drive
	input wire logic [N_PINS-1:0]             CORE_IN,               // Core inputs
	input wire logic [N_PINS-1:0]             ANALOG_EN,             // Analog paths
	input wire logic [N_PINS-1:0]             WAKE_INPUT_EN,         // Wake inputs
	input wire logic [N_PINS-1:0]             GPIO_FORCED,           // Forced ports
	input wire logic                          OSC_OUT_OE,            // Oscillator drive
	input wire logic                          RESET_PULLUP_EN,       // Reset pull-up
	input wire logic                          RESET_IN_EN,           // Reset input
	input wire logic [5:0]                    PHASE                  // Phase
);
	default clocking dc @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	// Pad states tied to phase, level bit and function, and the one-edge standby entry
	a_reset_pin_live: assert property (RESET_PULLUP_EN && RESET_IN_EN)
		else $error("reset pin pull-up or input dropped");
	a_reset_no_drive: assert property (PHASE == SPS_ST_RESET |-> PAD_OE == '0)
		else $error("pad driven in reset phase");
	a_analog_off: assert property (
		$stable(PIN_FUNC[8:6]) && PIN_FUNC[8:6] == `SPS_FUNC_ANALOG |-> !PAD_OE[2] && !CORE_IN[2] && ANALOG_EN[2])
		else $error("analog pin not isolated");
	a_stby_float: assert property (
		PHASE == SPS_ST_STBY && $past(PHASE) == SPS_ST_STBY && STANDBY_PIN_LEVEL_SEL && $stable(STANDBY_PIN_LEVEL_SEL)
		&& PIN_FUNC[2:0] == `SPS_FUNC_GPIO |-> !PAD_OE[0] && !CORE_IN[0])
		else $error("port pin not floated in standby");
	a_osc_stop: assert property (
		PHASE inside {SPS_ST_STBY, SPS_ST_DEEP} && $past(POWER_MODE) inside {`SPS_MODE_STBY_OSC, `SPS_MODE_DEEP_OSC}
		|-> !OSC_OUT_OE)
		else $error("oscillator output driven while stopped");
	a_stby_entry: assert property (
		PHASE == SPS_ST_RUN && POWER_MODE == `SPS_MODE_STBY && !INT_RESET && EXT_RESET_CORE |=> PHASE == SPS_ST_STBY)
		else $error("standby not entered one edge after request");
	a_deep_forced: assert property (
		PHASE == SPS_ST_DEEP && $past(PHASE) == SPS_ST_DEEP && PIN_FUNC[5:3] == `SPS_FUNC_PERI |-> GPIO_FORCED[1])
		else $error("peripheral pin not forced to port in deep standby");
	a_wake_deep: assert property (
		PHASE == SPS_ST_DEEP && $past(PHASE) == SPS_ST_DEEP && PIN_FUNC[14:12] == `SPS_FUNC_WAKE |-> WAKE_INPUT_EN[4])
		else $error("wake input off in deep standby");
endmodule : sps_pin_state_ctrl_asserts

bind sps_pin_state_ctrl sps_pin_state_ctrl_asserts #(.N_PINS(N_PINS)) u_sps_pin_state_ctrl_asserts (
	.CORE_CLK(CORE_CLK), .RESET(RESET), .INT_RESET(INT_RESET), .EXT_RESET_CORE(EXT_RESET_CORE),
	.POWER_MODE(POWER_MODE), .STANDBY_PIN_LEVEL_SEL(STANDBY_PIN_LEVEL_SEL),
	.PIN_FUNC(PIN_FUNC), .PAD_OE(PAD_OE), .CORE_IN(CORE_IN), .ANALOG_EN(ANALOG_EN), .WAKE_INPUT_EN(WAKE_INPUT_EN),
	.GPIO_FORCED(GPIO_FORCED), .OSC_OUT_OE(OSC_OUT_OE), .RESET_PULLUP_EN(RESET_PULLUP_EN),
	.RESET_IN_EN(RESET_IN_EN), .PHASE(PHASE));

// >>> dv/tb_top.sv
/* Self-checking bench for the standby pin-state controller.
   Assumes the pad model and the bound checker; pins hold every function code. */
`timescale 1ns/1ps
`include "sps_defines.svh"
module tb_top
	import sps_pkg::*;
;
	logic        clk, reset, ext_rst_n, int_rst, deep_ret, standby_pin_level_sel, mode_pad, osc_in, osc_drv;
	logic [2:0]  mode;
	logic [23:0] func;
	logic [7:0]  gpo, gpoe, po, poe, pad_in, pad_out, pad_oe, core_in, an_en, wk_en, forced;
	logic        osc_oe, osc_pad, osc_core, mode_core, pu_en, rin_en, xr_core;
	logic [5:0]  phase;
	int          miscompares, checked;

	sps_pin_state_ctrl #(.N_PINS(8)) u_sps_pin_state_ctrl (
		.CORE_CLK(clk), .RESET(reset), .EXT_RESET_N(ext_rst_n), .INT_RESET(int_rst), .POWER_MODE(mode),
		.DEEP_RETURN(deep_ret), .STANDBY_PIN_LEVEL_SEL(standby_pin_level_sel), .PIN_FUNC(func), .GPIO_OUT(gpo), .GPIO_OE(gpoe),
		.PERI_OUT(po), .PERI_OE(poe), .PAD_IN(pad_in), .OSC_OUT_DRIVE(osc_drv), .OSC_IN_PAD(osc_in),
		.MODE_PAD(mode_pad), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .CORE_IN(core_in), .ANALOG_EN(an_en),
		.WAKE_INPUT_EN(wk_en), .GPIO_FORCED(forced), .OSC_OUT_PAD(osc_pad), .OSC_OUT_OE(osc_oe),
		.OSC_IN_CORE(osc_core), .MODE_IN_CORE(mode_core), .RESET_PULLUP_EN(pu_en), .RESET_IN_EN(rin_en),
		.EXT_RESET_CORE(xr_core), .PHASE(phase));
	sps_pad_env #(.N(8)) u_sps_pad_env (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in));

	// 25 MHz core clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic print_verdict();
		$display("counts: %0d checked, %0d miscompares", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Let n edges pass, then settle past them
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wait_phase(input logic [5:0] p);
		int n;
		for (n = 0; n < 64 && phase !== p; n++)
			cyc(1);
		if (phase !== p)
		begin
			miscompares++;
			$display("unexpected at %0t: phase %h expected %h", $time, phase, p);
			print_verdict();
		end
	endtask : wait_phase

	task automatic t_run();
		wait_phase(SPS_ST_RUN);
		cyc(3);
		chk(pad_oe & 8'h83, 8'h83);
		chk(pad_out & 8'h83, 8'h03);
		chk(an_en, 8'h04);
		chk(core_in & 8'h05, 8'h01);
		$display("test run done");
	endtask : t_run

	// Enter standby, change port and peripheral data, then return to run
	task automatic t_stby(input logic s);
		@(posedge clk);
		standby_pin_level_sel <= s;
		mode <= s ? `SPS_MODE_STBY_OSC : `SPS_MODE_STBY;
		wait_phase(SPS_ST_STBY);
		@(posedge clk);
		gpo <= 8'h24;
		po <= 8'h58;
		osc_drv <= 1'b0;
		cyc(4);
		if (s)
		begin
			chk(pad_oe & 8'h81, 8'h00);
			chk(core_in & 8'h81, 8'h00);
			chk({7'h00, osc_oe}, 8'h00);
			chk(pad_oe & 8'h68, 8'h68);
		end
		else
		begin
			chk(pad_oe & 8'h81, 8'h81);
			chk(pad_out & 8'h83, 8'h01);
			chk({6'h00, osc_oe, osc_pad}, 8'h03);
		end
		@(posedge clk);
		mode <= `SPS_MODE_RUN;
		gpo <= 8'h25;
		po <= 8'h5A;
		osc_drv <= 1'b1;
		wait_phase(SPS_ST_RUN);
		$display("test standby level %0b done", s);
	endtask : t_stby

	task automatic t_ext_reset();
		@(posedge clk);
		ext_rst_n <= 1'b0;
		mode_pad <= 1'b0;
		osc_in <= 1'b0;
		wait_phase(SPS_ST_RESET);
		cyc(3);
		chk(pad_oe, 8'h00);
		chk(core_in, 8'h00);
		chk(an_en, 8'h04);
		chk({3'h0, xr_core, mode_core, osc_core, pu_en, rin_en}, 8'h03);
		@(posedge clk);
		ext_rst_n <= 1'b1;
		mode_pad <= 1'b1;
		osc_in <= 1'b1;
		wait_phase(SPS_ST_RUN);
		chk({6'h00, mode_core, osc_core}, 8'h03);
		$display("test pin reset done");
	endtask : t_ext_reset

	// Deep standby with stopped oscillator, then return through internal reset
	task automatic t_deep();
		@(posedge clk);
		standby_pin_level_sel <= 1'b1;
		mode <= `SPS_MODE_DEEP_OSC;
		wait_phase(SPS_ST_DEEP);
		cyc(3);
		chk(forced & 8'h0A, 8'h0A);
		chk({4'h0, wk_en[4], pad_oe[4], osc_oe, rin_en}, 8'h09);
		@(posedge clk);
		mode <= `SPS_MODE_RUN;
		standby_pin_level_sel <= 1'b0;
		deep_ret <= 1'b1;
		int_rst <= 1'b1;
		wait_phase(SPS_ST_RESET);
		chk(pad_oe, 8'h00);
		@(posedge clk);
		int_rst <= 1'b0;
		wait_phase(SPS_ST_RETURN);
		cyc(2);
		chk(forced & 8'h1A, 8'h1A);
		chk(wk_en, 8'h00);
		chk(pad_out & 8'h03, 8'h01);
		@(posedge clk);
		deep_ret <= 1'b0;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		wait_phase(SPS_ST_RUN);
		$display("test deep standby done");
	endtask : t_deep

	// Main sequence
	initial
	begin
		miscompares = 0;
		checked = 0;
		{reset, ext_rst_n, int_rst, deep_ret, standby_pin_level_sel, mode_pad, osc_in, osc_drv} = 8'hC7;
		mode = `SPS_MODE_RUN;
		func = {`SPS_FUNC_GPIO, `SPS_FUNC_JTAG, `SPS_FUNC_NMI, `SPS_FUNC_WAKE, `SPS_FUNC_EXTINT, `SPS_FUNC_ANALOG,
			`SPS_FUNC_PERI, `SPS_FUNC_GPIO};
		{gpo, gpoe, po, poe} = 32'h25FF_5AFF;
		repeat (19) @(posedge clk);
		#1;
		chk(pad_oe, 8'h00);
		chk({6'h00, pu_en, rin_en}, 8'h03);
		@(posedge clk);
		reset <= 1'b0;
		t_run();
		t_stby(1'b0);
		t_stby(1'b1);
		t_ext_reset();
		t_deep();
		print_verdict();
	end
endmodule : tb_top

// >>> inc/sps_defines.svh
/*
 * Constants for the standby pin-state controller: mode codes, function codes, reset values.
 * Assumes inclusion by the package and design files by bare name.
 */
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
`define SPS_MODE_W        3
`define SPS_MODE_RUN      3'h0
`define SPS_MODE_STBY     3'h1
`define SPS_MODE_STBY_OSC 3'h2
`define SPS_MODE_DEEP     3'h3
`define SPS_MODE_DEEP_OSC 3'h4
`define SPS_FUNC_W        3
`define SPS_FUNC_GPIO     3'h0
`define SPS_FUNC_PERI     3'h1
`define SPS_FUNC_ANALOG   3'h2
`define SPS_FUNC_EXTINT   3'h3
`define SPS_FUNC_WAKE     3'h4
`define SPS_FUNC_NMI      3'h5
`define SPS_FUNC_JTAG     3'h6
`define SPS_BIT_LO        1'h0
`define SPS_BIT_HI        1'h1
`define SPS_SYNC_ONES     2'h3
`define SPS_SYNC_ZEROS    2'h0
`endif

// >>> inc/sps_pkg.sv
/*
 * Types for the standby pin-state controller.
 * Assumes sps_defines.svh is on the include path.
 */
`include "sps_defines.svh"
package sps_pkg;
	// Power phases, one-hot
	typedef enum logic [5:0] {
		SPS_ST_RESET  = 6'b00_0001,
		SPS_ST_RUN    = 6'b00_0010,
		SPS_ST_STBY   = 6'b00_0100,
		SPS_ST_DEEP   = 6'b00_1000,
		SPS_ST_RETURN = 6'b01_0000,
		SPS_ST_SPARE  = 6'b10_0000
	} sps_state_t;
endpackage : sps_pkg

// >>> verilog/sps_pin_cell.sv
/*
 * One general pin cell: computes drive, enable and input gating for the phase given.
 * Assumes phase flags come registered from the controller, on the same clock.
 */
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_pin_cell
	import sps_pkg::*;
(
	input  wire logic                   clk,          // Core clock
	input  wire logic                   rst,          // Synchronous reset
	input  wire logic                   in_reset,     // Reset phase
	input  wire logic                   in_run,       // Run or return phase
	input  wire logic                   in_stby,      // Timer/RTC/sleep standby
	input  wire logic                   in_deep,      // Deep standby
	input  wire logic                   in_return,    // Returned from deep standby
	input  wire logic                   standby_pin_level_sel,          // Standby pin level bit
	input  wire logic [`SPS_FUNC_W-1:0] func,         // Software function selection
	input  wire logic                   gpio_out,     // Port output data
	input  wire logic                   gpio_oe,      // Port output enable
	input  wire logic                   peri_out,     // Peripheral output data
	input  wire logic                   peri_oe,      // Peripheral output enable
	input  wire logic                   pad_in_sync,  // Synchronised pad level
	output logic                        pad_out,      // Pad output data
	output logic                        pad_oe,       // Pad driver enable
	output logic                        core_in,      // Gated input to core
	output logic                        analog_en,    // Analog path enable
	output logic                        wake_en,      // Wake-up input active
	output logic                        gpio_forced   // Pin forced to port function
);
	logic [`SPS_FUNC_W-1:0] func_q;   // Effective function
	logic                   hold_o_q; // Latched port output
	logic                   hold_e_q; // Latched port enable
	logic                   forced_q; // Port-forced after deep standby

	// Effective function and port-forcing; forcing outlives the reset that ends deep standby
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			func_q   <= `SPS_FUNC_GPIO;
			forced_q <= `SPS_BIT_LO;
		end
		else if (in_reset)
			func_q <= `SPS_FUNC_GPIO;
		else if (in_deep && func != `SPS_FUNC_ANALOG && func != `SPS_FUNC_JTAG)
		begin
			func_q   <= (func == `SPS_FUNC_WAKE) ? `SPS_FUNC_WAKE : `SPS_FUNC_GPIO;
			forced_q <= (func != `SPS_FUNC_GPIO) | forced_q;
		end
		else if (in_run && !forced_q)
			func_q <= func;
		else if (in_run && forced_q && func == `SPS_FUNC_GPIO)
			forced_q <= `SPS_BIT_LO;                       // software reconfigures
	end

	// Port output latched while running, held in standby
	always_ff @(posedge clk)
	begin
		if (rst || in_reset)
		begin
			hold_o_q <= `SPS_BIT_LO;
			hold_e_q <= `SPS_BIT_LO;
		end
		else if (in_run)
		begin
			hold_o_q <= gpio_out;
			hold_e_q <= gpio_oe;
		end
	end

	wire is_analog = (func_q == `SPS_FUNC_ANALOG) || (func == `SPS_FUNC_ANALOG);
	wire is_peri   = (func_q == `SPS_FUNC_PERI) || (func_q == `SPS_FUNC_JTAG);
	wire is_extint = (func_q == `SPS_FUNC_EXTINT) || (func_q == `SPS_FUNC_NMI);
	wire is_wake   = (func_q == `SPS_FUNC_WAKE);
	wire keep_lvl  = (is_extint && !in_deep) || (func_q == `SPS_FUNC_JTAG);
	wire hiz_gate  = standby_pin_level_sel && (in_stby || in_deep) && !keep_lvl;
	wire peri_live = is_peri && !in_deep && !in_return;
	wire drv_en    = peri_live ? peri_oe : (in_run ? gpio_oe : hold_e_q);
	wire drv_dat   = peri_live ? peri_out : (in_run ? gpio_out : hold_o_q);
	wire gated     = is_analog || hiz_gate || in_reset;

	assign pad_oe      = !(is_analog || hiz_gate || in_reset) && drv_en;
	assign pad_out     = pad_oe ? drv_dat : `SPS_BIT_LO;
	assign core_in     = gated ? `SPS_BIT_LO : pad_in_sync;
	assign analog_en   = is_analog;
	assign wake_en     = is_wake && in_deep;
	assign gpio_forced = forced_q;
endmodule : sps_pin_cell

// >>> verilog/sps_pin_state_ctrl.sv
/*
 * Standby pin-state controller: tracks the power phase and drives per-pin pad controls.
 * Assumes the power controller presents mode and reset levels on CORE_CLK, pads arrive async.
 */
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_pin_state_ctrl
	import sps_pkg::*;
#(
	parameter int N_PINS = 8 // General pins
)
(
	input  wire logic                          CORE_CLK,        // 25 MHz core clock
	input  wire logic                          RESET,           // Synchronous reset, active high
	input  wire logic                          EXT_RESET_N,     // External reset pin level
	input  wire logic                          INT_RESET,       // Device internal reset
	input  wire logic [`SPS_MODE_W-1:0]        POWER_MODE,      // Requested power mode
	input  wire logic                          DEEP_RETURN,     // Returned from deep standby
	input  wire logic                          STANDBY_PIN_LEVEL_SEL, // Standby pin level bit
	input  wire logic [N_PINS*`SPS_FUNC_W-1:0] PIN_FUNC,        // Per-pin function selection
	input  wire logic [N_PINS-1:0]             GPIO_OUT,        // Port output data
	input  wire logic [N_PINS-1:0]             GPIO_OE,         // Port output enable
	input  wire logic [N_PINS-1:0]             PERI_OUT,        // Peripheral output data
	input  wire logic [N_PINS-1:0]             PERI_OE,         // Peripheral output enable
	input  wire logic [N_PINS-1:0]             PAD_IN,          // Pad levels
	input  wire logic                          OSC_OUT_DRIVE,   // Oscillator output drive
	input  wire logic                          OSC_IN_PAD,      // Oscillator input pad
	input  wire logic                          MODE_PAD,        // Mode input pad
	output logic      [N_PINS-1:0]             PAD_OUT,         // Pad output data
	output logic      [N_PINS-1:0]             PAD_OE,          // Pad driver enable
	output logic      [N_PINS-1:0]             CORE_IN,         // Gated inputs to core
	output logic      [N_PINS-1:0]             ANALOG_EN,       // Analog path enables
	output logic      [N_PINS-1:0]             WAKE_INPUT_EN,   // Wake inputs active
	output logic      [N_PINS-1:0]             GPIO_FORCED,     // Pins forced to port
	output logic                               OSC_OUT_PAD,     // Oscillator output pad data
	output logic                               OSC_OUT_OE,      // Oscillator output enable
	output logic                               OSC_IN_CORE,     // Oscillator input to core
	output logic                               MODE_IN_CORE,    // Mode input to core
	output logic                               RESET_PULLUP_EN, // Reset pin pull-up enable
	output logic                               RESET_IN_EN,     // Reset pin input enable
	output logic                               EXT_RESET_CORE,  // Synchronised reset pin to core
	output logic      [5:0]                    PHASE            // Current phase, one-hot
);
	sps_state_t        state_q;
	sps_state_t        state_d;
	logic [1:0]        ext_rst_sync_q;   // Reset pin synchroniser
	logic [N_PINS-1:0] pad_s1_q;
	logic [N_PINS-1:0] pad_s2_q;
	logic [1:0]        osc_sync_q;
	logic [1:0]        mode_sync_q;
	logic              osc_stop_q;       // Oscillator stopped in this phase
	logic              osc_hold_q;       // Oscillator output level held

	// Reset pin synchroniser, starts released so reset exit is not stretched
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			ext_rst_sync_q <= `SPS_SYNC_ONES;
		else
			ext_rst_sync_q <= {ext_rst_sync_q[0], EXT_RESET_N};
	end

	// General pad synchroniser, two stages
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			pad_s1_q <= '0;
			pad_s2_q <= '0;
		end
		else
		begin
			pad_s1_q <= PAD_IN;
			pad_s2_q <= pad_s1_q;
		end
	end

	// Oscillator input synchroniser
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			osc_sync_q <= `SPS_SYNC_ZEROS;
		else
			osc_sync_q <= {osc_sync_q[0], OSC_IN_PAD};
	end

	// Mode pin synchroniser
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			mode_sync_q <= `SPS_SYNC_ZEROS;
		else
			mode_sync_q <= {mode_sync_q[0], MODE_PAD};
	end

	wire ext_rst_n_s = ext_rst_sync_q[1];
	wire any_reset   = !ext_rst_n_s || INT_RESET;
	wire mode_stby   = (POWER_MODE == `SPS_MODE_STBY) || (POWER_MODE == `SPS_MODE_STBY_OSC);
	wire mode_deep   = (POWER_MODE == `SPS_MODE_DEEP) || (POWER_MODE == `SPS_MODE_DEEP_OSC);
	wire mode_ostop  = (POWER_MODE == `SPS_MODE_STBY_OSC) || (POWER_MODE == `SPS_MODE_DEEP_OSC);

	// Phase selection
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			SPS_ST_RESET:
			begin
				if (any_reset)
					state_d = SPS_ST_RESET;
				else if (DEEP_RETURN)
					state_d = SPS_ST_RETURN;
				else
					state_d = SPS_ST_RUN;
			end
			SPS_ST_RUN:
			begin
				if (mode_deep)
					state_d = SPS_ST_DEEP;
				else if (mode_stby)
					state_d = SPS_ST_STBY;
				else
					state_d = SPS_ST_RUN;
			end
			SPS_ST_STBY:
			begin
				if (mode_stby)
					state_d = SPS_ST_STBY;
				else
					state_d = SPS_ST_RUN;
			end
			SPS_ST_DEEP:
			begin
				if (mode_deep)
					state_d = SPS_ST_DEEP;
				else
					state_d = SPS_ST_RETURN;
			end
			SPS_ST_RETURN:
			begin
				if (mode_deep)
					state_d = SPS_ST_DEEP;
				else if (mode_stby)
					state_d = SPS_ST_STBY;
				else
					state_d = SPS_ST_RETURN;
			end
			default:
				state_d = SPS_ST_RESET;
		endcase
		if (any_reset && state_q != SPS_ST_DEEP)
			state_d = SPS_ST_RESET;
	end

	// Phase register, one edge per transition
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			state_q <= SPS_ST_RESET;
		else
			state_q <= state_d;
	end

	// Oscillator stop and held level
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			osc_stop_q <= `SPS_BIT_LO;
			osc_hold_q <= `SPS_BIT_LO;
		end
		else
		begin
			osc_stop_q <= mode_ostop && (state_d == SPS_ST_STBY || state_d == SPS_ST_DEEP);
			if (state_q == SPS_ST_RUN)
				osc_hold_q <= OSC_OUT_DRIVE;
		end
	end

	wire in_reset  = (state_q == SPS_ST_RESET);
	wire in_run    = (state_q == SPS_ST_RUN);
	wire in_stby   = (state_q == SPS_ST_STBY);
	wire in_deep   = (state_q == SPS_ST_DEEP);
	wire in_return = (state_q == SPS_ST_RETURN);

	// One cell per general pin
	genvar g;
	generate
		for (g = 0; g < N_PINS; g++)
		begin : g_pin
			sps_pin_cell u_cell (
				.clk         (CORE_CLK),
				.rst         (RESET),
				.in_reset    (in_reset),
				.in_run      (in_run || in_return),
				.in_stby     (in_stby),
				.in_deep     (in_deep),
				.in_return   (in_return),
				.standby_pin_level_sel         (STANDBY_PIN_LEVEL_SEL),
				.func        (PIN_FUNC[g*`SPS_FUNC_W +: `SPS_FUNC_W]),
				.gpio_out    (GPIO_OUT[g]),
				.gpio_oe     (GPIO_OE[g]),
				.peri_out    (PERI_OUT[g]),
				.peri_oe     (PERI_OE[g]),
				.pad_in_sync (pad_s2_q[g]),
				.pad_out     (PAD_OUT[g]),
				.pad_oe      (PAD_OE[g]),
				.core_in     (CORE_IN[g]),
				.analog_en   (ANALOG_EN[g]),
				.wake_en     (WAKE_INPUT_EN[g]),
				.gpio_forced (GPIO_FORCED[g])
			);
		end
	endgenerate

	// Oscillator output: drive while running, hold in standby, float when stopped
	wire osc_float = in_reset || osc_stop_q;
	assign OSC_OUT_OE  = !osc_float;
	assign OSC_OUT_PAD = osc_float ? `SPS_BIT_LO : (in_run ? OSC_OUT_DRIVE : osc_hold_q);

	// Always-enabled inputs, and the phase output
	assign OSC_IN_CORE     = osc_sync_q[1];
	assign MODE_IN_CORE    = mode_sync_q[1];
	assign RESET_PULLUP_EN = `SPS_BIT_HI;
	assign RESET_IN_EN     = `SPS_BIT_HI;
	assign EXT_RESET_CORE  = ext_rst_n_s;
	assign PHASE           = state_q;
endmodule : sps_pin_state_ctrl
